/* File: logic/phy_selfid_ctrl.sv */
// Purpose: self-ID control bits, resume watch, short reset request and timeout flags
// Assumes: one clock, async active-low reset, AXI4-Lite register access
// Notes: pins from outside pass a three-stage synchroniser
//
// Notes on behaviour
// - self-ID link bit is control AND power-status
// - link control sets on reset, survives bus reset
// - interface operational only from power-status input
// - contender bit copied into self-ID
// - contender clears on reset, software-only set
// - jitter field reads zero, read-only
// - power class copied into self-ID
// - power class loads pins at reset release
// - resume watch sets port event flag
// - resume watch clears on reset, survives bus reset
// - short reset request starts short bus reset
// - short reset request clears on bus reset
// - config timeout flag sets on tree-ID timeout
// - config timeout cleared by writing one
// - link-on output asserted for inactive link
// - config timeout only with legacy nodes
// - state timeout flag sets and starts reset
`timescale 1ns/1ps
module phy_selfid_ctrl
  import phy_regs_pkg::*;
#(
  parameter int SHORT_CYC = SHORT_RESET_CYC
) (
  input wire logic ref_clk, // 125 MHz clock
  input wire logic rstn, // async reset, active low
  input wire logic clkEn, // freezes all state while low
  // axi4-lite slave
  input wire logic [5:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // write strobes
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [5:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  // device side
  input wire logic linkPowerStatusInput, // link power status pin
  input wire logic [2:0] powerClassPins, // power class strap pins
  input wire logic busReset, // bus reset pulse, same clock
  input wire logic treeIdTimeout, // tree-ID start timeout pulse
  input wire logic legacyPresent, // legacy nodes in topology
  input wire logic identTimeout, // tree/self-ID wait timeout pulse
  input wire logic resumeStart, // resume begun on any port
  input wire logic cablePowerFlag, // cable power flag level
  input wire logic shortResetDone, // arbiter finished short reset
  output selfid_fields_t selfId, // fields for the self-ID packet
  output logic linkOperational, // link interface usable
  output logic shortResetStart, // one-cycle start of short reset
  output logic busResetRequest, // one-cycle reset after state timeout
  output logic linkOnOutput, // request service from link
  output logic irq // level interrupt
);

  // synchronisers for pins
  logic [2:0] lpsSync_ff; // stage 0 read only by stage 1
  logic [2:0] pcSync0_ff, pcSync1_ff, pcSync2_ff; // power class stages
  logic lpsActive_ff; // filtered power status
  logic strapDone_ff; // power class caught once after reset
  logic [2:0] strapFill_ff; // ones shift in as the pin stages fill

  // register state
  logic linkActive_ff, contender_ff, resumeWatch_ff, shortReq_ff;
  logic [2:0] pwrClass_ff;
  logic cfgTimeout_ff, stateTimeout_ff, portEvent_ff;
  logic [IRQ_BITS-1:0] irqStatus_ff, irqMask_ff;
  logic cpfPrev_ff; // edge detect on cable power flag
  logic [15:0] resetCnt_ff; // short reset in progress counter

  // axi handshake state
  logic [5:0] wAddr_ff;
  logic wAddrHave_ff, wDataHave_ff;
  logic [31:0] wData_ff;
  logic [3:0] wStrb_ff;

  // synchronise power status; change counts when stages 1 and 2 agree
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      lpsSync_ff <= 3'h0;
      lpsActive_ff <= 1'b0;
    end else if (clkEn) begin
      lpsSync_ff <= {lpsSync_ff[1:0], linkPowerStatusInput};
      if (lpsSync_ff[1] == lpsSync_ff[2]) begin
        lpsActive_ff <= lpsSync_ff[2];
      end
    end
  end

  // synchronise power class pins
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pcSync0_ff <= 3'h0;
      pcSync1_ff <= 3'h0;
      pcSync2_ff <= 3'h0;
    end else if (clkEn) begin
      pcSync0_ff <= powerClassPins;
      pcSync1_ff <= pcSync0_ff;
      pcSync2_ff <= pcSync1_ff;
    end
  end

  // interface state from power status only
  assign linkOperational = lpsActive_ff;

  // write channel decode
  logic wrFire;
  logic wrSel4, wrSel5, wrSel9;
  assign wrFire = wAddrHave_ff && wDataHave_ff && !bvalid;
  assign wrSel4 = wrFire && wStrb_ff[0] && (wAddr_ff == SELFID_LINK_POWER_CTRL_ADDR);
  assign wrSel5 = wrFire && wStrb_ff[0] && (wAddr_ff == INTERRUPT_AND_RESET_CTRL_ADDR);
  assign wrSel9 = wrFire && wStrb_ff[0] && (wAddr_ff == IRQ_MASK_ADDR);

  // address and data taken in either order
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wAddrHave_ff <= 1'b0;
      wDataHave_ff <= 1'b0;
      wAddr_ff <= 6'h00;
      wData_ff <= 32'h0000_0000;
      wStrb_ff <= 4'h0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (clkEn) begin
      if (awvalid && awready) begin
        wAddrHave_ff <= 1'b1;
        wAddr_ff <= awaddr;
      end
      if (wvalid && wready) begin
        wDataHave_ff <= 1'b1;
        wData_ff <= wdata;
        wStrb_ff <= wstrb;
      end
      if (wrFire) begin
        wAddrHave_ff <= 1'b0;
        wDataHave_ff <= 1'b0;
        bvalid <= 1'b1;
        // unmapped addresses answer with slave error
        bresp <= (wAddr_ff == SELFID_LINK_POWER_CTRL_ADDR ||
                  wAddr_ff == INTERRUPT_AND_RESET_CTRL_ADDR ||
                  wAddr_ff == IRQ_STATUS_ADDR ||
                  wAddr_ff == IRQ_MASK_ADDR) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ready while the holding slot is empty
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      awready <= 1'b0;
      wready <= 1'b0;
    end else if (clkEn) begin
      awready <= !wAddrHave_ff && !(awvalid && awready) && !wrFire;
      wready <= !wDataHave_ff && !(wvalid && wready) && !wrFire;
    end
  end

  // strap capture four cycles after release once the last two stages agree, then software owned
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      strapDone_ff <= 1'b0;
      strapFill_ff <= 3'h0;
      pwrClass_ff <= PWR_RST;
    end else if (clkEn) begin
      strapFill_ff <= {strapFill_ff[1:0], 1'b1};
      if (!strapDone_ff) begin
        // load pins after reset
        // stages still hold reset zeros until filled, so wait for them
        strapDone_ff <= strapFill_ff[2] && (pcSync1_ff == pcSync2_ff);
        pwrClass_ff <= pcSync2_ff;
      end else if (wrSel4) begin
        pwrClass_ff <= wData_ff[PWR_LSB +: 3];
      end
    end
  end

  // control bits of the self-ID register; bus reset leaves them
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      linkActive_ff <= LINK_ACTIVE_RST;
      contender_ff <= CONTENDER_RST;
    end else if (clkEn && wrSel4) begin
      // jitter bits of the write are dropped
      linkActive_ff <= wData_ff[LINK_ACTIVE_POS];
      contender_ff <= wData_ff[CONTENDER_POS];
    end
  end

  // resume watch cleared by reset or a software write, bus reset leaves it
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      resumeWatch_ff <= RESUME_WATCH_RST;
    end else if (clkEn && wrSel5) begin
      resumeWatch_ff <= wData_ff[RESUME_WATCH_POS];
    end
  end

  // short reset request and its timed execution
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      shortReq_ff <= 1'b0;
      shortResetStart <= 1'b0;
      resetCnt_ff <= 16'h0000;
    end else if (clkEn) begin
      shortResetStart <= 1'b0;
      if (busReset || shortResetDone) begin
        shortReq_ff <= 1'b0;
        resetCnt_ff <= 16'h0000;
      end else if (wrSel5 && wData_ff[SHORT_RESET_POS]) begin
        shortReq_ff <= 1'b1;
      end else if (shortReq_ff && resetCnt_ff == 16'h0000) begin
        // start short reset at next opportunity
        shortResetStart <= 1'b1;
        resetCnt_ff <= SHORT_CYC[15:0] - 16'h0001;
      end else if (resetCnt_ff != 16'h0000) begin
        // runs down to zero so a pending request starts again
        resetCnt_ff <= resetCnt_ff - 16'h0001;
      end
    end
  end

  // flag set conditions
  logic cfgSet, cpfRise, portSet;
  // tree-ID timeout sets flag; legacy nodes only
  assign cfgSet = treeIdTimeout && legacyPresent;
  assign cpfRise = cablePowerFlag && !cpfPrev_ff;
  // resume start or new flag with link down
  assign portSet = resumeWatch_ff &&
                   (resumeStart || (!lpsActive_ff && (cfgSet || cpfRise || identTimeout)));

  // sticky flags, set wins over write-one clear
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cfgTimeout_ff <= 1'b0;
      stateTimeout_ff <= 1'b0;
      portEvent_ff <= 1'b0;
      cpfPrev_ff <= 1'b0;
    end else if (clkEn) begin
      cpfPrev_ff <= cablePowerFlag;
      if (cfgSet) begin
        cfgTimeout_ff <= 1'b1;
      end else if (wrSel5 && wData_ff[CFG_TIMEOUT_POS]) begin
        cfgTimeout_ff <= 1'b0;
      end
      if (identTimeout) begin
        stateTimeout_ff <= 1'b1;
      end else if (wrSel5 && wData_ff[STATE_TIMEOUT_POS]) begin
        stateTimeout_ff <= 1'b0;
      end
      if (portSet) begin
        portEvent_ff <= 1'b1;
      end else if (wrSel5 && wData_ff[PORT_EVENT_POS]) begin
        portEvent_ff <= 1'b0;
      end
    end
  end

  // state timeout forces a bus reset
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      busResetRequest <= 1'b0;
    end else if (clkEn) begin
      busResetRequest <= identTimeout;
    end
  end

  // link-on when flag, watch and link down
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      linkOnOutput <= 1'b0;
    end else if (clkEn) begin
      linkOnOutput <= cfgTimeout_ff && resumeWatch_ff && !lpsActive_ff;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      selfId <= '0;
    end else if (clkEn) begin
      selfId.linkActive <= linkActive_ff && lpsActive_ff;
      selfId.contender <= contender_ff;
      selfId.pwrClass <= pwrClass_ff;
    end
  end

  // read-clears-status interrupt unit
  logic rdFire, rdStatus;
  logic [IRQ_BITS-1:0] irqEvents;
  assign rdFire = arvalid && arready;
  assign rdStatus = rdFire && (araddr == IRQ_STATUS_ADDR);
  assign irqEvents = {identTimeout, portSet, cfgSet};

  // events win over the clearing read
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irqStatus_ff <= '0;
      irqMask_ff <= '0;
    end else if (clkEn) begin
      irqStatus_ff <= (rdStatus ? '0 : irqStatus_ff) | irqEvents;
      if (wrSel9) begin
        irqMask_ff <= wData_ff[IRQ_BITS-1:0];
      end
    end
  end

  // level interrupt from a flop
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else if (clkEn) begin
      irq <= |(irqStatus_ff & irqMask_ff);
    end
  end

  // read data assembly
  logic [31:0] rdVal;
  logic rdOk;
  always_comb begin
    rdVal = 32'h0000_0000;
    rdOk = 1'b1;
    case (araddr)
      SELFID_LINK_POWER_CTRL_ADDR: begin
        rdVal[LINK_ACTIVE_POS] = linkActive_ff;
        rdVal[CONTENDER_POS] = contender_ff;
        rdVal[JITTER_LSB +: 3] = JITTER_VALUE;
        rdVal[PWR_LSB +: 3] = pwrClass_ff;
      end
      INTERRUPT_AND_RESET_CTRL_ADDR: begin
        rdVal[RESUME_WATCH_POS] = resumeWatch_ff;
        rdVal[SHORT_RESET_POS] = shortReq_ff;
        rdVal[CFG_TIMEOUT_POS] = cfgTimeout_ff;
        rdVal[CABLE_POWER_POS] = cablePowerFlag;
        rdVal[STATE_TIMEOUT_POS] = stateTimeout_ff;
        rdVal[PORT_EVENT_POS] = portEvent_ff;
      end
      IRQ_STATUS_ADDR: rdVal[IRQ_BITS-1:0] = irqStatus_ff;
      IRQ_MASK_ADDR: rdVal[IRQ_BITS-1:0] = irqMask_ff;
      default: rdOk = 1'b0;
    endcase
  end

  // read channel, one read outstanding
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else if (clkEn) begin
      arready <= !rvalid && !rdFire;
      if (rdFire) begin
        rvalid <= 1'b1;
        rdata <= rdVal;
        rresp <= rdOk ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // checks
  a_selfid_link: assert property (@(posedge ref_clk) disable iff (!rstn)
    clkEn |=> selfId.linkActive == ($past(linkActive_ff) && $past(lpsActive_ff)))
    else $error("self-ID link bit wrong");
  a_cfg_set: assert property (@(posedge ref_clk) disable iff (!rstn)
    clkEn && cfgSet |=> cfgTimeout_ff)
    else $error("config timeout not set");
  a_legacy_only: assert property (@(posedge ref_clk) disable iff (!rstn)
    clkEn && !cfgTimeout_ff && !legacyPresent |=> !cfgTimeout_ff)
    else $error("config timeout without legacy");
  a_short_clear: assert property (@(posedge ref_clk) disable iff (!rstn)
    clkEn && busReset |=> !shortReq_ff)
    else $error("short request survived bus reset");
  a_short_start: assert property (@(posedge ref_clk) disable iff (!rstn)
    clkEn && shortReq_ff && resetCnt_ff == 16'h0000 && !busReset && !shortResetDone
    && !wrSel5 |=> shortResetStart)
    else $error("short reset not started");
  a_link_on: assert property (@(posedge ref_clk) disable iff (!rstn)
    clkEn && cfgTimeout_ff && resumeWatch_ff && !lpsActive_ff |=> linkOnOutput)
    else $error("link-on not raised");
  a_port_event: assert property (@(posedge ref_clk) disable iff (!rstn)
    clkEn && resumeWatch_ff && resumeStart |=> portEvent_ff)
    else $error("port event not set");
  a_state_reset: assert property (@(posedge ref_clk) disable iff (!rstn)
    clkEn && identTimeout |=> busResetRequest && stateTimeout_ff)
    else $error("state timeout not handled");
  a_jitter_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
    rvalid && $rose(rvalid) && $past(araddr) == SELFID_LINK_POWER_CTRL_ADDR
    |-> rdata[JITTER_LSB +: 3] == JITTER_VALUE)
    else $error("jitter field not zero");
  a_contender_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
    !wrSel4 |=> $stable(contender_ff))
    else $error("contender changed without write");
  a_watch_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
    !wrSel5 |=> $stable(resumeWatch_ff))
    else $error("resume watch changed without write");

endmodule // phy_selfid_ctrl

/* File: logic/phy_regs_pkg.sv */
// Purpose: shared constants and carrier types for the self-ID control register bank
// Assumes: AXI4-Lite, 32-bit data, one aligned word per register
// Notes: register indices are kept and the byte address is four times the index
package phy_regs_pkg;

  // register indices and byte addresses
  localparam logic [3:0] SELFID_LINK_POWER_CTRL_IDX = 4'h4;
  localparam logic [3:0] INTERRUPT_AND_RESET_CTRL_IDX = 4'h5;
  localparam logic [3:0] IRQ_STATUS_IDX = 4'h8;
  localparam logic [3:0] IRQ_MASK_IDX = 4'h9;
  localparam logic [5:0] SELFID_LINK_POWER_CTRL_ADDR = {SELFID_LINK_POWER_CTRL_IDX, 2'b00};
  localparam logic [5:0] INTERRUPT_AND_RESET_CTRL_ADDR = {INTERRUPT_AND_RESET_CTRL_IDX, 2'b00};
  localparam logic [5:0] IRQ_STATUS_ADDR = {IRQ_STATUS_IDX, 2'b00};
  localparam logic [5:0] IRQ_MASK_ADDR = {IRQ_MASK_IDX, 2'b00};

  // field positions in the self-ID control register (bit 7 is the msb of the byte)
  localparam int LINK_ACTIVE_POS = 7;
  localparam int CONTENDER_POS = 6;
  localparam int JITTER_LSB = 3;
  localparam int PWR_LSB = 0;

  // field positions in the interrupt and reset control register
  localparam int RESUME_WATCH_POS = 7;
  localparam int SHORT_RESET_POS = 6;
  localparam int CFG_TIMEOUT_POS = 5;
  localparam int CABLE_POWER_POS = 4;
  localparam int STATE_TIMEOUT_POS = 3;
  localparam int PORT_EVENT_POS = 2;

  // interrupt status bit positions
  localparam int IRQ_CFG_TIMEOUT = 0;
  localparam int IRQ_PORT_EVENT = 1;
  localparam int IRQ_STATE_TIMEOUT = 2;
  localparam int IRQ_BITS = 3;

  // reset values
  localparam logic LINK_ACTIVE_RST = 1'b1;
  localparam logic CONTENDER_RST = 1'b0;
  localparam logic RESUME_WATCH_RST = 1'b0;
  localparam logic [2:0] JITTER_VALUE = 3'h0;
  localparam logic [2:0] PWR_RST = 3'h0;

  // timing
  localparam int JITTER_STEP_NS = 20;
  localparam int SHORT_RESET_NS = 1300;
  localparam int CLK_PERIOD_NS = 8;
  localparam int SHORT_RESET_CYC = SHORT_RESET_NS / CLK_PERIOD_NS;

  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // self-ID fields handed to the packet builder
  typedef struct packed {
    logic linkActive;
    logic contender;
    logic [2:0] pwrClass;
  } selfid_fields_t;

  // status flags of this bank
  typedef struct packed {
    logic cfgTimeout;
    logic portEvent;
    logic stateTimeout;
    logic shortReset;
  } flags_t;

endpackage

/* File: testbench/llc_model.sv */
// Purpose: link-layer controller model, AXI4-Lite master of the register bank
// Assumes: one clock, every request changes right after a rising edge
// Notes: waits have no limit of their own; the bench watchdog ends a hang
`timescale 1ns/1ps
module llc_model (
  input wire logic ref_clk, // bank clock
  output logic [5:0] awaddr = 6'h00, // write address
  output logic awvalid = 1'b0, // write address valid
  input wire logic awready, // write address taken
  output logic [31:0] wdata = 32'h0, // write data
  output logic wvalid = 1'b0, // write data valid
  input wire logic wready, // write data taken
  input wire logic [1:0] bresp, // write response
  input wire logic bvalid, // write response valid
  output logic bready = 1'b0, // write response ready
  output logic [5:0] araddr = 6'h00, // read address
  output logic arvalid = 1'b0, // read address valid
  input wire logic arready, // read address taken
  input wire logic [31:0] rdata, // read data
  input wire logic [1:0] rresp, // read response
  input wire logic rvalid, // read data valid
  output logic rready = 1'b0 // read data ready
);
  // one write: address and data offered together, each dropped when taken
  task automatic wr(input logic [5:0] a, input logic [7:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    fork
      begin
        do @(posedge ref_clk); while (awready !== 1'b1);
        awvalid <= 1'b0;
      end
      begin
        do @(posedge ref_clk); while (wready !== 1'b1);
        wvalid <= 1'b0;
      end
    join
    // the response can only follow both channels
    do @(posedge ref_clk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  // one read: data taken at the edge that shows rvalid
  task automatic rd(input logic [5:0] a, output logic [7:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge ref_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge ref_clk); while (rvalid !== 1'b1);
    d = rdata[7:0];
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule // llc_model

/* File: testbench/phy_selfid_ctrl_and_irq_bits_tb.sv */
// Purpose: self-checking bench of the self-ID control and interrupt bits
// Assumes: short reset repeat shortened to 4 cycles
// Notes: shortResetDone, clkEn and wstrb are held constant
`timescale 1ns/1ps
module phy_selfid_ctrl_and_irq_bits_tb;
  import phy_regs_pkg::*;
  typedef struct packed {
    logic [5:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } row_t;
  logic ref_clk = 1'b0; // 125 MHz
  logic rstn = 1'b0; // held low at start
  logic linkPowerStatusInput = 1'b1; // link powered
  logic [2:0] powerClassPins = 3'h5; // strap value
  logic busReset = 1'b0, treeIdTimeout = 1'b0, identTimeout = 1'b0, resumeStart = 1'b0;
  logic legacyPresent = 1'b0; // no legacy nodes yet
  logic cablePowerFlag = 1'b0; // cable power flag level
  logic [5:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp, resp;
  logic [7:0] rdv;
  logic irqA; // irq seen under the first mask
  selfid_fields_t selfId;
  logic linkOperational, shortResetStart, busResetRequest, linkOnOutput, irq;
  int n_fail = 0;
  int checked = 0;
  // jitter bits of a write must read back as zero
  row_t rows[5] = '{'{6'h10, 8'hFF, 8'hC7}, '{6'h10, 8'h78, 8'h40}, '{6'h10, 8'h83, 8'h83},
                    '{6'h14, 8'h80, 8'h80}, '{6'h14, 8'h00, 8'h00}};

  phy_selfid_ctrl #(.SHORT_CYC(4)) i_phy_selfid_ctrl (.ref_clk, .rstn, .clkEn(1'b1), .awaddr,
    .awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .linkPowerStatusInput,
    .powerClassPins, .busReset, .treeIdTimeout, .legacyPresent, .identTimeout, .resumeStart,
    .cablePowerFlag, .shortResetDone(1'b0), .selfId, .linkOperational, .shortResetStart,
    .busResetRequest, .linkOnOutput, .irq);

  llc_model i_llc_model (.ref_clk, .awaddr, .awvalid, .awready, .wdata, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);

  // clock
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t ns: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wrc(input logic [5:0] a, input logic [7:0] d);
    logic [1:0] r;
    i_llc_model.wr(a, d, r);
    chk(r, RESP_OKAY);
  endtask
  task automatic rdc(input logic [5:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] d;
    logic [1:0] r;
    i_llc_model.rd(a, d, r);
    chk(r, RESP_OKAY);
    chk(d & m, e);
  endtask
  // one-cycle pulse: 0 bus reset, 1 tree-ID timeout, 2 ident timeout, 3 resume
  task automatic pls(input int k);
    @(posedge ref_clk);
    case (k)
      0: busReset <= 1'b1;
      1: treeIdTimeout <= 1'b1;
      2: identTimeout <= 1'b1;
      default: resumeStart <= 1'b1;
    endcase
    @(posedge ref_clk);
    {busReset, treeIdTimeout, identTimeout, resumeStart} <= 4'h0;
  endtask
  // bounded wait for a pulse: 0 short reset start, 1 bus reset request
  task automatic waitFor(input int s);
    int k;
    k = 0;
    while ((s ? busResetRequest : shortResetStart) !== 1'b1 && k < 20) begin
      @(posedge ref_clk);
      k++;
    end
    chk(k < 20, 1);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // watchdog, far beyond the few hundred cycles the run needs
  initial begin
    #200000;
    n_fail++;
    print_verdict();
  end

  initial begin
    tick(10);
    rstn <= 1'b1;
    tick(8);
    // ordinary writes and read-back, self-ID fields follow the register
    foreach (rows[i]) begin
      wrc(rows[i].a, rows[i].d);
      rdc(rows[i].a, 8'hFC, rows[i].e & 8'hFC);
      if (rows[i].a == 6'h10) chk(selfId, {rows[i].e[7:6], rows[i].e[2:0]});
    end
    // link indication needs both control bit and power status
    wrc(SELFID_LINK_POWER_CTRL_ADDR, 8'h80);
    linkPowerStatusInput <= 1'b0;
    tick(8);
    chk({linkOperational, selfId.linkActive}, 2'b00);
    linkPowerStatusInput <= 1'b1;
    wrc(SELFID_LINK_POWER_CTRL_ADDR, 8'h00);
    tick(8);
    chk({linkOperational, selfId.linkActive}, 2'b10);
    // second reset in mid-run with other strap levels
    powerClassPins <= 3'h2;
    rstn <= 1'b0;
    tick(10);
    rstn <= 1'b1;
    tick(8);
    rdc(SELFID_LINK_POWER_CTRL_ADDR, 8'hFF, 8'h82);
    rdc(INTERRUPT_AND_RESET_CTRL_ADDR, 8'hFC, 8'h00);
    chk(selfId.linkActive, 1'b1);
    // bus reset keeps settings but drops the short reset request
    wrc(SELFID_LINK_POWER_CTRL_ADDR, 8'h45);
    wrc(INTERRUPT_AND_RESET_CTRL_ADDR, 8'hC0); // resume watch and short reset
    waitFor(0);
    pls(0);
    rdc(SELFID_LINK_POWER_CTRL_ADDR, 8'hFF, 8'h45);
    rdc(INTERRUPT_AND_RESET_CTRL_ADDR, 8'hFC, 8'h80);
    // config timeout only with legacy nodes present
    pls(1);
    tick(6);
    rdc(INTERRUPT_AND_RESET_CTRL_ADDR, 8'hFC, 8'h80);
    legacyPresent <= 1'b1;
    pls(1);
    tick(6);
    rdc(INTERRUPT_AND_RESET_CTRL_ADDR, 8'hFC, 8'hA0);
    linkPowerStatusInput <= 1'b0;
    tick(8);
    chk(linkOnOutput, 1'b1);
    wrc(INTERRUPT_AND_RESET_CTRL_ADDR, 8'h80);
    rdc(INTERRUPT_AND_RESET_CTRL_ADDR, 8'hFC, 8'hA0);
    wrc(INTERRUPT_AND_RESET_CTRL_ADDR, 8'hA0);
    tick(3);
    chk(linkOnOutput, 1'b0);
    rdc(INTERRUPT_AND_RESET_CTRL_ADDR, 8'hFC, 8'h80);
    // flag set while the link is down also raises the port event
    pls(1);
    tick(6);
    rdc(INTERRUPT_AND_RESET_CTRL_ADDR, 8'hFC, 8'hA4);
    chk(linkOnOutput, 1'b1);
    wrc(INTERRUPT_AND_RESET_CTRL_ADDR, 8'hA4);
    // cable power flag rising while the link is down
    cablePowerFlag <= 1'b1;
    tick(4);
    rdc(INTERRUPT_AND_RESET_CTRL_ADDR, 8'hFC, 8'h94);
    cablePowerFlag <= 1'b0;
    wrc(INTERRUPT_AND_RESET_CTRL_ADDR, 8'h84);
    linkPowerStatusInput <= 1'b1;
    rdc(INTERRUPT_AND_RESET_CTRL_ADDR, 8'hFC, 8'h80);
    // resume start counts only while the watch is enabled
    pls(3);
    tick(4);
    rdc(INTERRUPT_AND_RESET_CTRL_ADDR, 8'hFC, 8'h84);
    wrc(INTERRUPT_AND_RESET_CTRL_ADDR, 8'h04);
    pls(3);
    tick(4);
    rdc(INTERRUPT_AND_RESET_CTRL_ADDR, 8'hFC, 8'h00);
    // state timeout: flag and a bus reset request
    rdc(IRQ_STATUS_ADDR, 8'hFF, 8'h03);
    pls(2);
    waitFor(1);
    rdc(INTERRUPT_AND_RESET_CTRL_ADDR, 8'hFC, 8'h08);
    // the two mask settings must disagree on irq
    wrc(IRQ_MASK_ADDR, 8'h00);
    tick(2);
    irqA = irq;
    wrc(IRQ_MASK_ADDR, 8'h07);
    tick(2);
    chk({irqA, irq}, 2'b01);
    rdc(IRQ_STATUS_ADDR, 8'hFF, 8'h04);
    tick(2);
    chk(irq, 1'b0);
    rdc(IRQ_STATUS_ADDR, 8'hFF, 8'h00);
    // unmapped address is refused
    i_llc_model.wr(6'h3C, 8'h00, resp);
    chk(resp, RESP_SLVERR);
    i_llc_model.rd(6'h3C, rdv, resp);
    chk(resp, RESP_SLVERR);
    print_verdict();
  end
endmodule // phy_selfid_ctrl_and_irq_bits_tb
